// ==== pifl_irq.sv ====
`default_nettype none
module pifl_irq
  import pifl_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Host bus
  input wire logic i_select_active_high,
  input wire logic i_select_active_low_n,
  input wire logic i_read_write_n,
  input wire logic [3:0] i_register_select_lines,
  input wire logic [7:0] i_host_data_bus,
  output logic [7:0] o_host_data_bus,
  output logic o_host_data_oe,
  // Other units
  input wire pifl_src_t i_set_events,
  input wire pifl_mode_t i_mode,
  input wire logic [7:0] i_other_read_data,
  // Interrupt request
  output logic o_irq_request_n
);
  pifl_state_t st_ff;
  pifl_state_t nxt_st;
  logic sel;
  logic rd;
  logic wr;
  logic summary;
  logic [6:0] set_v;
  logic [6:0] clr_v;
  logic [6:0] active_v;

  assign sel = i_select_active_high && !i_select_active_low_n;
  assign rd = sel && i_read_write_n;
  assign wr = sel && !i_read_write_n;
  assign set_v = i_set_events;
  assign active_v = st_ff.flags & st_ff.enables;
  assign summary = |active_v;

  always_comb begin
    nxt_st = st_ff;
    clr_v = '0;
    // Register decode; port and shift accesses, timer low-byte reads or high-byte writes, and flag writes clear source flags
    if (!sel) begin
      clr_v = '0;
    end else if (i_register_select_lines == PIFL_REG_PORT_B_OUT) begin
      clr_v[PIFL_BIT_B_CTL_ONE] = 1'b1;
      clr_v[PIFL_BIT_B_CTL_TWO] = !i_mode.port_b_two_independent;
    end else if (i_register_select_lines == PIFL_REG_PORT_A_OUT) begin
      clr_v[PIFL_BIT_A_CTL_ONE] = 1'b1;
      clr_v[PIFL_BIT_A_CTL_TWO] = !i_mode.port_a_two_independent;
    end else if (i_register_select_lines == PIFL_REG_SHIFT) begin
      clr_v[PIFL_BIT_SHIFT] = 1'b1;
    end else if (i_register_select_lines == PIFL_REG_TIMER_TWO_LOW) begin
      clr_v[PIFL_BIT_TIMER_TWO] = rd;
    end else if (i_register_select_lines == PIFL_REG_TIMER_TWO_HIGH) begin
      clr_v[PIFL_BIT_TIMER_TWO] = wr;
    end else if (i_register_select_lines == PIFL_REG_TIMER_ONE_COUNT_LOW) begin
      clr_v[PIFL_BIT_TIMER_ONE] = rd;
    end else if (i_register_select_lines == PIFL_REG_TIMER_ONE_LATCH_HIGH) begin
      clr_v[PIFL_BIT_TIMER_ONE] = wr;
    end else if (i_register_select_lines == PIFL_REG_FLAG_STATUS) begin
      // Bit 7 of the written byte is ignored
      clr_v = wr ? i_host_data_bus[6:0] : 7'h00;
    end else if (i_register_select_lines == PIFL_REG_ENABLE_MASK) begin
      if (wr && i_host_data_bus[PIFL_BIT_TOP]) begin
        nxt_st.enables = st_ff.enables | i_host_data_bus[6:0];
      end else if (wr) begin
        nxt_st.enables = st_ff.enables & ~i_host_data_bus[6:0];
      end
    end
    // Flags hold until cleared; a same-cycle set wins
    nxt_st.flags = (st_ff.flags & ~clr_v) | set_v;
    // Shift flag is held low while the shifter is disabled
    if (i_mode.shift_disabled) begin
      nxt_st.flags[PIFL_BIT_SHIFT] = 1'b0;
    end
    // Read data is captured on each read access; bus is released when not reading
    nxt_st.rd_oe = rd;
    if (rd) begin
      if (i_register_select_lines == PIFL_REG_FLAG_STATUS) begin
        nxt_st.rd_data = {summary, st_ff.flags};
      end else if (i_register_select_lines == PIFL_REG_ENABLE_MASK) begin
        nxt_st.rd_data = {PIFL_ENABLE_READ_TOP, st_ff.enables};
      end else begin
        nxt_st.rd_data = i_other_read_data;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_ff.flags <= PIFL_FLAGS_RST;
      st_ff.enables <= PIFL_ENABLES_RST;
      st_ff.rd_data <= PIFL_RD_DATA_RST;
      st_ff.rd_oe <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Data holds its last value while the bus is released
  assign o_host_data_bus = st_ff.rd_data;
  assign o_host_data_oe = st_ff.rd_oe;
  // Always driven both ways
  assign o_irq_request_n = !summary;

  a_irq_follows_set: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (|(set_v & st_ff.enables) && !(wr && i_register_select_lines == PIFL_REG_ENABLE_MASK)
     && !i_mode.shift_disabled)
    |=> !o_irq_request_n)
    else $error("request not low after enabled flag set");

  a_summary_read: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (rd && i_register_select_lines == PIFL_REG_FLAG_STATUS)
    |=> o_host_data_oe && (o_host_data_bus[7] == !$past(o_irq_request_n))
    && (o_host_data_bus[6:0] == $past(st_ff.flags)))
    else $error("flag read mismatches state");

  a_flag_write_clear: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (wr && i_register_select_lines == PIFL_REG_FLAG_STATUS && set_v == 7'h00
     && !i_mode.shift_disabled)
    |=> ((st_ff.flags & $past(i_host_data_bus[6:0])) == 7'h00)
    && ((st_ff.flags | $past(i_host_data_bus[6:0])) ==
        ($past(st_ff.flags) | $past(i_host_data_bus[6:0]))))
    else $error("flag write did not clear ones only");

  a_top_write_inert: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (wr && i_register_select_lines == PIFL_REG_FLAG_STATUS && i_host_data_bus == 8'h80
     && !i_mode.shift_disabled)
    |=> st_ff.flags == ($past(st_ff.flags) | $past(set_v)))
    else $error("writing summary bit changed flags");

  a_enable_clear: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (wr && i_register_select_lines == PIFL_REG_ENABLE_MASK && !i_host_data_bus[7])
    |=> st_ff.enables == ($past(st_ff.enables) & ~$past(i_host_data_bus[6:0])))
    else $error("enable clear wrong");

  a_enable_set: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (wr && i_register_select_lines == PIFL_REG_ENABLE_MASK && i_host_data_bus[7])
    |=> st_ff.enables == ($past(st_ff.enables) | $past(i_host_data_bus[6:0])))
    else $error("enable set wrong");

  a_enable_read: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (rd && i_register_select_lines == PIFL_REG_ENABLE_MASK)
    |=> o_host_data_bus == {1'b1, $past(st_ff.enables)})
    else $error("enable read wrong");

  a_flags_sticky: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (!sel && !i_mode.shift_disabled)[*2]
    |-> (st_ff.flags & $past(st_ff.flags)) == $past(st_ff.flags))
    else $error("flag self-cleared");

  a_timer_read_clear: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (rd && i_register_select_lines == PIFL_REG_TIMER_ONE_COUNT_LOW && !i_set_events.timer_one)
    |=> !st_ff.flags[PIFL_BIT_TIMER_ONE])
    else $error("timer one flag not cleared");

  a_timer_two_clear: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (wr && i_register_select_lines == PIFL_REG_TIMER_TWO_HIGH && !i_set_events.timer_two)
    |=> !st_ff.flags[PIFL_BIT_TIMER_TWO])
    else $error("timer two flag not cleared");

  a_port_b_clear: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (sel && i_register_select_lines == PIFL_REG_PORT_B_OUT && !i_set_events.port_b_control_one)
    |=> !st_ff.flags[PIFL_BIT_B_CTL_ONE])
    else $error("port line flag not cleared");

  a_indep_kept: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (sel && i_register_select_lines == PIFL_REG_PORT_A_OUT && i_mode.port_a_two_independent)
    |=> (st_ff.flags[PIFL_BIT_A_CTL_TWO] == $past(st_ff.flags[PIFL_BIT_A_CTL_TWO])
    || $past(i_set_events.port_a_control_two)))
    else $error("independent flag cleared by port access");

  a_shift_held_low: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_mode.shift_disabled |=> !st_ff.flags[PIFL_BIT_SHIFT])
    else $error("shift flag set while shifter off");

  a_bus_release: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    !rd |=> !o_host_data_oe && $stable(o_host_data_bus))
    else $error("bus driven when not reading");

  a_reset_clears: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    $fell(i_sys_rst) |-> st_ff.flags == 7'h00 && st_ff.enables == 7'h00 && o_irq_request_n)
    else $error("reset left state");

  a_set_wins: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (rd && i_register_select_lines == PIFL_REG_TIMER_ONE_COUNT_LOW && i_set_events.timer_one)
    |=> st_ff.flags[PIFL_BIT_TIMER_ONE])
    else $error("set lost to clear");
endmodule : pifl_irq
`default_nettype wire

// ==== pifl_pkg.sv ====
`default_nettype none
package pifl_pkg;
  // Register select codes on the four select lines
  localparam logic [3:0] PIFL_REG_PORT_B_OUT = 4'h0;
  localparam logic [3:0] PIFL_REG_PORT_A_OUT = 4'h1;
  localparam logic [3:0] PIFL_REG_TIMER_ONE_COUNT_LOW = 4'h4;
  localparam logic [3:0] PIFL_REG_TIMER_ONE_LATCH_HIGH = 4'h7;
  localparam logic [3:0] PIFL_REG_TIMER_TWO_LOW = 4'h8;
  localparam logic [3:0] PIFL_REG_TIMER_TWO_HIGH = 4'h9;
  localparam logic [3:0] PIFL_REG_SHIFT = 4'hA;
  localparam logic [3:0] PIFL_REG_FLAG_STATUS = 4'hD;
  localparam logic [3:0] PIFL_REG_ENABLE_MASK = 4'hE;

  // Bit positions shared by the flag and enable registers
  localparam int PIFL_BIT_A_CTL_TWO = 0;
  localparam int PIFL_BIT_A_CTL_ONE = 1;
  localparam int PIFL_BIT_SHIFT = 2;
  localparam int PIFL_BIT_B_CTL_TWO = 3;
  localparam int PIFL_BIT_B_CTL_ONE = 4;
  localparam int PIFL_BIT_TIMER_TWO = 5;
  localparam int PIFL_BIT_TIMER_ONE = 6;
  localparam int PIFL_BIT_TOP = 7;

  // Reset values
  localparam logic [6:0] PIFL_FLAGS_RST = 7'h00;
  localparam logic [6:0] PIFL_ENABLES_RST = 7'h00;
  localparam logic [7:0] PIFL_RD_DATA_RST = 8'h00;
  localparam logic PIFL_ENABLE_READ_TOP = 1'b1;

  // Set pulses from the timer, shift and port units, msb = bit 6
  typedef struct packed {
    logic timer_one;
    logic timer_two;
    logic port_b_control_one;
    logic port_b_control_two;
    logic shift_register;
    logic port_a_control_one;
    logic port_a_control_two;
  } pifl_src_t;

  // Configuration levels from the peripheral control and aux units
  typedef struct packed {
    logic port_a_two_independent;
    logic port_b_two_independent;
    logic shift_disabled;
  } pifl_mode_t;

  typedef struct packed {
    logic [6:0] flags;
    logic [6:0] enables;
    logic [7:0] rd_data;
    logic rd_oe;
  } pifl_state_t;
endpackage : pifl_pkg
`default_nettype wire

// ==== pifl_host.sv ====
`default_nettype none
module pifl_host (
  // Clock
  input wire logic i_ref_clk,
  // Device read side
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_oe,
  // Bus drive
  output logic o_sel_high,
  output logic o_sel_low_n,
  output logic o_rw_n,
  output logic [3:0] o_reg_sel,
  output logic [7:0] o_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_sel_high = 1'b0;
    o_sel_low_n = 1'b1;
    o_rw_n = 1'b1;
    o_reg_sel = 4'h0;
    o_wr_data = 8'h00;
  end

  // One bus cycle, entered just after a falling edge and held to the next one
  task automatic access(input logic sel, input logic alt, input logic rw, input logic [3:0] a,
                        input logic [7:0] wd, output logic [7:0] rd, output logic oe);
    // Unselected cycles get one select wrong, alt picks which one
    o_sel_high = sel | alt;
    o_sel_low_n = !sel & alt;
    o_rw_n = rw;
    o_reg_sel = a;
    o_wr_data = wd;
    @(negedge i_ref_clk);
    rd = i_rd_data;
    oe = i_rd_oe;
  endtask : access
endmodule : pifl_host
`default_nettype wire

// ==== pifl_irq_tb_top.sv ====
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module pifl_irq_tb_top
  import pifl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sel_high, sel_low_n, rw_n, data_oe, irq_n;
  logic [3:0] reg_sel;
  logic [7:0] wr_data, rd_data;
  logic [7:0] other_data = 8'h00;
  pifl_src_t set_ev = '0;
  pifl_mode_t mode = '0;
  logic [31:0] seed = 32'h0000_2345;
  logic [31:0] r;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int flags, enables, last_rd;

  always #10 ref_clk = ~ref_clk;

  pifl_irq pifl_irq_inst (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
    .i_select_active_high(sel_high), .i_select_active_low_n(sel_low_n),
    .i_read_write_n(rw_n), .i_register_select_lines(reg_sel), .i_host_data_bus(wr_data),
    .o_host_data_bus(rd_data), .o_host_data_oe(data_oe), .i_set_events(set_ev),
    .i_mode(mode), .i_other_read_data(other_data), .o_irq_request_n(irq_n));

  pifl_host pifl_host_inst (.i_ref_clk(ref_clk), .i_rd_data(rd_data), .i_rd_oe(data_oe),
    .o_sel_high(sel_high), .o_sel_low_n(sel_low_n), .o_rw_n(rw_n), .o_reg_sel(reg_sel),
    .o_wr_data(wr_data));

  function logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : next_rand

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // One host cycle with set pulses beside it, mirrored in the integer model
  task automatic step(input logic sel, input logic alt, input logic rw, input logic [3:0] a,
                      input logic [7:0] wd, input logic [6:0] ev);
    logic [7:0] rd, exp_rd;
    logic oe;
    int clr;
    clr = 0;
    other_data = 8'(next_rand());
    if (a == PIFL_REG_FLAG_STATUS) exp_rd = {|(flags & enables), 7'(flags)};
    else if (a == PIFL_REG_ENABLE_MASK) exp_rd = {PIFL_ENABLE_READ_TOP, 7'(enables)};
    else exp_rd = other_data;
    if (sel) begin
      if (a == PIFL_REG_PORT_B_OUT) begin
        clr = 1 << PIFL_BIT_B_CTL_ONE;
        if (!mode.port_b_two_independent) clr |= 1 << PIFL_BIT_B_CTL_TWO;
      end
      if (a == PIFL_REG_PORT_A_OUT) begin
        clr = 1 << PIFL_BIT_A_CTL_ONE;
        if (!mode.port_a_two_independent) clr |= 1 << PIFL_BIT_A_CTL_TWO;
      end
      if (a == PIFL_REG_SHIFT) clr = 1 << PIFL_BIT_SHIFT;
      if ((a == PIFL_REG_TIMER_TWO_LOW && rw) || (a == PIFL_REG_TIMER_TWO_HIGH && !rw))
        clr = 1 << PIFL_BIT_TIMER_TWO;
      if ((a == PIFL_REG_TIMER_ONE_COUNT_LOW && rw) ||
          (a == PIFL_REG_TIMER_ONE_LATCH_HIGH && !rw))
        clr = 1 << PIFL_BIT_TIMER_ONE;
      if (a == PIFL_REG_FLAG_STATUS && !rw) clr = wd[6:0];
      if (a == PIFL_REG_ENABLE_MASK && !rw)
        enables = wd[7] ? (enables | wd[6:0]) : (enables & ~wd[6:0]);
    end
    set_ev = pifl_src_t'(ev);
    pifl_host_inst.access(sel, alt, rw, a, wd, rd, oe);
    // Set pulses win over clears; shift-off mode pins the shift flag low
    flags = ((flags & ~clr) | ev) & (mode.shift_disabled ? 32'h0000_007B : 32'h0000_007F);
    if (sel && rw) last_rd = exp_rd;
    `CHK(oe, sel & rw)
    `CHK(rd, 8'(last_rd))
    `CHK(irq_n, !(|(flags & enables)))
  endtask : step

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    for (int k = 0; k < 2; k++) begin
      logic [7:0] rd;
      logic oe;
      sys_rst = 1'b1;
      set_ev = '0;
      mode = '0;
      repeat (8) pifl_host_inst.access(1'b0, 1'b0, 1'b1, 4'h0, 8'h00, rd, oe);
      sys_rst = 1'b0;
      flags = 0;
      enables = 0;
      last_rd = 0;
      `CHK(irq_n, 1'b1)
      `CHK(data_oe, 1'b0)
      `CHK(rd_data, PIFL_RD_DATA_RST)
      step(1'b1, 1'b0, 1'b1, PIFL_REG_FLAG_STATUS, 8'h00, 7'h00);
      step(1'b1, 1'b0, 1'b1, PIFL_REG_ENABLE_MASK, 8'h00, 7'h00);
      // Summary bit written alone must leave every flag as it was
      step(1'b1, 1'b0, 1'b0, PIFL_REG_ENABLE_MASK, 8'hFF, 7'h00);
      step(1'b0, 1'b1, 1'b1, 4'h0, 8'h00, 7'h7F);
      step(1'b1, 1'b0, 1'b0, PIFL_REG_FLAG_STATUS, 8'h80, 7'h00);
      step(1'b1, 1'b0, 1'b1, PIFL_REG_FLAG_STATUS, 8'h00, 7'h00);
      step(1'b1, 1'b0, 1'b0, PIFL_REG_FLAG_STATUS, 8'h7F, 7'h00);
      repeat (600) begin
        r = next_rand();
        mode = pifl_mode_t'(r[31:29] & r[28:26]);
        step(r[0] | r[1], r[2], r[3], r[7:4], r[15:8], 7'(r[22:16] & r[25:19]));
      end
      $display("test pass %0d done", k);
    end
    print_verdict();
  end
endmodule : pifl_irq_tb_top
`default_nettype wire
